//--- shared/ppm_defines.vh
// Purpose: Constants for the printer port pin bit map block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only; included by bare name.
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// Register byte offsets on the APB.
`define PPM_ADDR_W 12
`define PPM_OFS_STATUS 12'h000
`define PPM_OFS_CONTROL 12'h004
`define PPM_OFS_CONFIG 12'h008

// Printer status register bit positions.
`define PPM_ST_FAULT 3
`define PPM_ST_SELECTED 4
`define PPM_ST_PAPER_OUT 5
`define PPM_ST_ACK 6
`define PPM_ST_NOT_BUSY 7

// Printer control register bit positions and reset value.
`define PPM_CT_STROBE 0
`define PPM_CT_AUTOFEED 1
`define PPM_CT_INIT 2
`define PPM_CT_SELECT 3
`define PPM_CT_W 8
`define PPM_CT_RESET 8'h00

// Configuration index base addresses chosen by the strap.
`define PPM_CFG_BASE_LOW 16'h002E
`define PPM_CFG_BASE_HIGH 16'h004E

// Cycles after reset release before the synchronised strap is caught.
`define PPM_STRAP_DELAY 2'h2

`endif

//--- hdl/ppm_sync2.v
// Purpose: Two flip-flop synchroniser for one asynchronous pin.
// Assumes: The pin may change at any time relative to clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none

module ppm_sync2 (
   input wire clk,
   input wire rst_n,
   input wire async_in,
   input wire [0:0] reset_value,
   output wire sync_out
);

   reg stage_a;
   reg stage_b;

   // Two stages clear metastability before any logic reads the pin.
   // The reset value is a constant tied at the instance, never a live signal.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_a <= 1'b0;
         stage_b <= 1'b0;
      end else begin
         stage_a <= async_in ^ reset_value[0];
         stage_b <= stage_a;
      end
   end

   assign sync_out = stage_b ^ reset_value[0];

endmodule

`default_nettype wire

//--- hdl/ppm_port_map.v
// Purpose: Printer port handshake pins mapped onto status and control register bits.
// Assumes: APB slave with zero wait states; every pin input is asynchronous to clk.
// Notes: The configuration select strap is caught once after each reset release.
//    Printer control pins lag the control register by one clock.
//    A cleared control register leaves the initialise output low, holding the printer in reset.
//    Unmapped reads return zero with an error; writes to read-only words are dropped quietly.
//    Status bits follow the pins through a two-stage synchroniser, two clocks behind.
// Operation
// - Paper-out input reads uninverted on status bit 5.
// - Busy input reads inverted on status bit 7.
// - Acknowledge input reads directly on status bit 6.
// - Fault input reads directly on status bit 3.
// - Autofeed output is inverse of control bit 1.
// - Strobe output is inverse of control bit 0.
// - Strap sampled once at reset end, then held.
// - Strap zero gives base 02E, one gives 04E.
// - Initialise output follows control bit 2 directly.
// - Select output is inverse of control bit 3.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ppm_defines.vh"

module ppm_port_map (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   input wire paper_out_in,
   input wire printer_busy_in,
   input wire printer_acknowledge_n,
   input wire printer_fault_n,
   input wire printer_selected_in,
   input wire config_select_pin,
   output reg auto_line_feed_n,
   output reg data_strobe_n,
   output reg printer_initialise_n,
   output reg printer_select_out_n,
   output reg system_option_strap,
   output reg [15:0] config_index_base
);

   // Synchronised pin levels.
   wire paper_out_s;
   wire busy_s;
   wire ack_n_s;
   wire fault_n_s;
   wire selected_s;
   wire cfg_sel_s;

   // Register state.
   reg [`PPM_CT_W-1:0] control;
   reg [1:0] release_count;
   reg strap_taken;
   reg [7:0] status_byte;
   reg [31:0] next_prdata;
   reg addr_hit;

   // Transfer decodes and next pin levels.
   wire setup_phase;
   wire access_phase;
   wire read_setup;
   wire control_write;
   wire strap_due;
   wire next_auto_line_feed_n;
   wire next_data_strobe_n;
   wire next_printer_initialise_n;
   wire next_printer_select_out_n;

   // Every pin passes two flip-flops before the register logic reads it.
   // Inputs that idle high reset high through the synchroniser, so no false level follows reset.
   // The strap pin shares the same synchroniser so its level is safe to catch.
   ppm_sync2 u_sync_paper (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(paper_out_in),
      .reset_value(1'b0),
      .sync_out(paper_out_s)
   );
   ppm_sync2 u_sync_busy (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(printer_busy_in),
      .reset_value(1'b0),
      .sync_out(busy_s)
   );
   ppm_sync2 u_sync_ack (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(printer_acknowledge_n),
      .reset_value(1'b1),
      .sync_out(ack_n_s)
   );
   ppm_sync2 u_sync_fault (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(printer_fault_n),
      .reset_value(1'b1),
      .sync_out(fault_n_s)
   );
   ppm_sync2 u_sync_sel (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(printer_selected_in),
      .reset_value(1'b0),
      .sync_out(selected_s)
   );
   ppm_sync2 u_sync_cfg (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(config_select_pin),
      .reset_value(1'b0),
      .sync_out(cfg_sel_s)
   );

   // The slave never inserts wait states.
   assign pready = 1'b1;
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;

   // A read acts at its setup edge and a write at its completing access edge.
   assign read_setup = setup_phase & ~pwrite;
   assign control_write = access_phase & pwrite & pready & (paddr == `PPM_OFS_CONTROL);

   // Status byte assembled from the live synchronised pins; low bits read zero.
   // Only busy is inverted; the other status inputs read at their pin level.
   always @* begin
      status_byte = 8'h00;
      status_byte[`PPM_ST_PAPER_OUT] = paper_out_s;
      status_byte[`PPM_ST_NOT_BUSY] = ~busy_s;
      status_byte[`PPM_ST_ACK] = ack_n_s;
      status_byte[`PPM_ST_FAULT] = fault_n_s;
      status_byte[`PPM_ST_SELECTED] = selected_s;
   end

   // Address decode and read data selection for the current request.
   // Only exact word addresses hit; any other offset reads zero and raises the error.
   always @* begin
      addr_hit = 1'b1;
      next_prdata = 32'h00000000;
      case (paddr)
         `PPM_OFS_STATUS: next_prdata = {24'h000000, status_byte};
         `PPM_OFS_CONTROL: next_prdata = {24'h000000, control};
         `PPM_OFS_CONFIG: next_prdata = {15'h0000, system_option_strap, config_index_base};
         default: addr_hit = 1'b0;
      endcase
   end

   // An unmapped address answers with an error in the access phase.
   // It is combinational, so it stands only while that access phase stands.
   assign pslverr = access_phase & ~addr_hit;

   // Read data is captured in the setup phase so it is stable from a flip-flop in the access phase.
   // A pin change in the setup cycle itself is seen by the next read, not this one.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (read_setup) begin
         prdata <= next_prdata;
      end
   end

   // Control register takes a write at the completing access edge.
   // Writes to the status and configuration words are dropped without an error.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control <= `PPM_CT_RESET;
      end else if (control_write) begin
         control <= pwdata[`PPM_CT_W-1:0];
      end
   end

   // Pin levels from the control bits; all but initialise are the inverse of their bit.
   assign next_auto_line_feed_n = ~control[`PPM_CT_AUTOFEED];
   assign next_data_strobe_n = ~control[`PPM_CT_STROBE];
   assign next_printer_initialise_n = control[`PPM_CT_INIT];
   assign next_printer_select_out_n = ~control[`PPM_CT_SELECT];

   // Printer control pins follow the control register one cycle later.
   // Registering them keeps decode glitches off the printer cable.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_line_feed_n <= 1'b1;
         data_strobe_n <= 1'b1;
         printer_initialise_n <= 1'b0;
         printer_select_out_n <= 1'b1;
      end else begin
         auto_line_feed_n <= next_auto_line_feed_n;
         data_strobe_n <= next_data_strobe_n;
         printer_initialise_n <= next_printer_initialise_n;
         printer_select_out_n <= next_printer_select_out_n;
      end
   end

   // The strap is due once the synchroniser has refilled after release and nothing was caught yet.
   // Waiting those clocks keeps a reset-value stage from being taken for the pin.
   assign strap_due = !strap_taken && (release_count == `PPM_STRAP_DELAY);

   // The strap is caught once, then frozen until the next reset.
   // Later pin changes are ignored, as the strap only chooses a board option.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         release_count <= 2'h0;
         strap_taken <= 1'b0;
         system_option_strap <= 1'b0;
         config_index_base <= `PPM_CFG_BASE_LOW;
      end else if (strap_due) begin
         strap_taken <= 1'b1;
         system_option_strap <= cfg_sel_s;
         config_index_base <= cfg_sel_s ? `PPM_CFG_BASE_HIGH : `PPM_CFG_BASE_LOW;
      end else if (!strap_taken) begin
         release_count <= release_count + 2'h1;
      end
   end

endmodule

`default_nettype wire

//--- verif/ppm_checker.sv
// Purpose: Port-level checks for the printer port map.
// Assumes: Pins are held steady around status reads.
// Notes: Bound to the top module by the bench.
`timescale 1ns/10ps
`default_nettype none
module ppm_checker (
   input wire clk, rst_n, psel, penable, pwrite, pready, pslverr, config_select_pin,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire paper_out_in, printer_busy_in, printer_acknowledge_n, printer_fault_n, printer_selected_in,
   input wire auto_line_feed_n, data_strobe_n, printer_initialise_n, printer_select_out_n,
   input wire system_option_strap,
   input wire [15:0] config_index_base
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Access phases of a control write and a status read.
   wire wr_ctl = psel && penable && pwrite && paddr == 12'h004;
   wire rd_st = psel && penable && !pwrite && paddr == 12'h000;
   strobe_map_a: assert property (wr_ctl |-> ##2 data_strobe_n == !$past(pwdata[0], 2)) else $error("strobe");
   autofeed_map_a: assert property (wr_ctl |-> ##2 auto_line_feed_n == !$past(pwdata[1], 2)) else $error("feed");
   init_map_a: assert property (wr_ctl |-> ##2 printer_initialise_n == $past(pwdata[2], 2)) else $error("init");
   select_map_a: assert property (wr_ctl |-> ##2 printer_select_out_n == !$past(pwdata[3], 2)) else $error("sel");
   status_bits_a: assert property (rd_st |->
      prdata[7:3] == {!$past(printer_busy_in, 3),
      $past(printer_acknowledge_n, 3), $past(paper_out_in, 3), $past(printer_selected_in, 3),
      $past(printer_fault_n, 3)}) else $error("status");
   strap_catch_a: assert property ($rose(rst_n) |-> ##3 system_option_strap == config_select_pin) else $error("strap");
   strap_hold_a: assert property ($past(rst_n, 4) |-> $stable(system_option_strap)) else $error("hold");
   base_choice_a: assert property (config_index_base == (system_option_strap ? 16'h004E : 16'h002E)) else $error("base");
   bad_addr_a: assert property (psel && penable && paddr > 12'h008 |-> pslverr && pready) else $error("unmapped");
endmodule
`default_nettype wire

//--- verif/ppm_printer_model.sv
// Purpose: Printer at the far side of the port pins.
// Assumes: Paper, fault, selected and an acknowledge hold are set by the bench.
// Notes: Busy stays up for a few cycles after the strobe ends; ack pulses in the last of them.
`timescale 1ns/10ps
`default_nettype none
module ppm_printer_model #(parameter int DELAY = 4) (
   input wire logic clk,
   input wire logic data_strobe_n,
   input wire logic [3:0] cond,
   output logic busy, ack_n, paper_out, fault_n, selected
);
   logic [3:0] cnt = 4'h0;
   // Busy hold-off counter restarted by every strobe cycle.
   always @(posedge clk) begin
      if (!data_strobe_n) cnt <= 4'(DELAY);
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
   // Handshake and condition lines.
   assign busy = !data_strobe_n || cnt != 4'h0;
   assign ack_n = (cnt != 4'h1) && !cond[3];
   assign paper_out = cond[0];
   assign fault_n = !cond[1];
   assign selected = cond[2];
endmodule
`default_nettype wire

//--- verif/printer_port_pin_bit_map_bench.sv
// Purpose: Random bench for the printer port map.
// Assumes: Zero wait state slave, but the master waits for pready anyway.
// Notes: Two resets catch the strap at both levels.
`timescale 1ns/10ps
`default_nettype none
module printer_port_pin_bit_map_bench;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, config_select_pin = 0, pready, pslverr, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, r;
   logic paper_out_in, printer_busy_in, printer_acknowledge_n, printer_fault_n, printer_selected_in;
   logic auto_line_feed_n, data_strobe_n, printer_initialise_n, printer_select_out_n, system_option_strap;
   logic [15:0] config_index_base;
   logic [3:0] cond = 0;
   int mismatches = 0, checks_done = 0, cyc = 0;
   ppm_port_map uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .paper_out_in(paper_out_in),
      .printer_busy_in(printer_busy_in), .printer_acknowledge_n(printer_acknowledge_n),
      .printer_fault_n(printer_fault_n), .printer_selected_in(printer_selected_in),
      .config_select_pin(config_select_pin), .auto_line_feed_n(auto_line_feed_n),
      .data_strobe_n(data_strobe_n), .printer_initialise_n(printer_initialise_n),
      .printer_select_out_n(printer_select_out_n), .system_option_strap(system_option_strap),
      .config_index_base(config_index_base));
   ppm_printer_model prt (.clk(clk), .data_strobe_n(data_strobe_n), .cond(cond), .busy(printer_busy_in),
      .ack_n(printer_acknowledge_n), .paper_out(paper_out_in), .fault_n(printer_fault_n),
      .selected(printer_selected_in));
   // Clock and hang guard.
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         mismatches++;
         summarize;
      end
   end
   function automatic logic [31:0] exp_status(input logic [31:0] v);
      return {24'h0, ~v[0], ~v[11], v[8], v[10], ~v[9], 3'h0};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Main sequence under two strap levels.
   initial begin
      void'($urandom(32'h6ca5));
      for (int s = 0; s < 2; s++) begin
         rst_n <= 0;
         config_select_pin <= s[0];
         repeat (12) @(posedge clk);
         rst_n <= 1;
         repeat (5) @(posedge clk);
         apb(0, 12'h008, 0);
         chk(q, {15'h0, s[0], s[0] ? 16'h004E : 16'h002E});
         apb(0, 12'h00C, 0);
         chk({q[30:0], e}, 32'h1);
         repeat (40) begin
            r = $urandom;
            cond <= r[11:8];
            apb(1, 12'h004, r);
            repeat (20) @(posedge clk);
            chk(32'({data_strobe_n, auto_line_feed_n, printer_initialise_n, printer_select_out_n}),
               32'({~r[0], ~r[1], r[2], ~r[3]}));
            apb(0, 12'h000, 0);
            chk(q, exp_status(r));
            apb(0, 12'h004, 0);
            chk(q, {24'h0, r[7:0]});
         end
      end
      summarize;
   end
endmodule
bind ppm_port_map ppm_checker chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .config_select_pin(config_select_pin), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .paper_out_in(paper_out_in), .printer_busy_in(printer_busy_in),
   .printer_acknowledge_n(printer_acknowledge_n), .printer_fault_n(printer_fault_n),
   .printer_selected_in(printer_selected_in), .auto_line_feed_n(auto_line_feed_n),
   .data_strobe_n(data_strobe_n), .printer_initialise_n(printer_initialise_n),
   .printer_select_out_n(printer_select_out_n), .system_option_strap(system_option_strap),
   .config_index_base(config_index_base));
`default_nettype wire
